// [src/fsk_uart_pkg.sv]
// shared constants, register map and state types of the fsk character uart
package fsk_uart_pkg;

  // ==========================================================
  // clock and line rates
  localparam int CLK_HZ   = 10_000_000;
  localparam int RATE_HI  = 1200;
  localparam int RATE_MID = 150;
  localparam int RATE_LO  = 75;
  localparam int CYC_HI   = CLK_HZ / RATE_HI;
  localparam int CYC_MID  = CLK_HZ / RATE_MID;
  localparam int CYC_LO   = CLK_HZ / RATE_LO;
  localparam int CNT_W    = 18;

  // ==========================================================
  // register offsets (byte addresses)
  localparam logic [7:0] OFS_MOD_CFG  = 8'h00;
  localparam logic [7:0] OFS_LINE_FMT = 8'h04;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h08;
  localparam logic [7:0] OFS_TX_DATA  = 8'h0c;
  localparam logic [7:0] OFS_RX_DATA  = 8'h10;
  localparam logic [7:0] OFS_FLAGS    = 8'h14;

  // ==========================================================
  // field positions
  localparam int MOD_HI_RATE  = 0;
  localparam int MOD_TX_EN    = 1;
  localparam int MOD_TX_ASYNC = 3;
  localparam int MOD_RX_ASYNC = 7;
  localparam int FMT_DATA8    = 0;
  localparam int FMT_PAR_EVEN = 1;
  localparam int FMT_PAR_EN   = 2;
  localparam int FMT_STOP2    = 3;
  localparam int FMT_TXINV    = 6;
  localparam int FMT_SLOW150  = 7;
  localparam int FLG_TX_RDY   = 0;
  localparam int FLG_TX_UND   = 1;
  localparam int FLG_RX_RDY   = 2;
  localparam int FLG_RX_OVF   = 3;
  localparam int FLG_RING_CHG = 5;
  localparam int FLG_RING     = 6;
  localparam int FLG_BAD_PAR  = 7;
  localparam logic [7:0] FLG_EVENTS = 8'h2f;

  // ==========================================================
  // reset value and data bit counts
  localparam logic [7:0] RST_REG  = 8'h00;
  localparam logic [3:0] DATA_N8  = 4'h8;
  localparam logic [3:0] DATA_N7  = 4'h7;

  typedef enum logic [2:0] {
    TX_IDLE = 3'b000, TX_START = 3'b001, TX_DATA = 3'b011,
    TX_PAR  = 3'b010, TX_STOP  = 3'b110
  } tx_state_type;

  typedef enum logic [2:0] {
    RX_IDLE = 3'b000, RX_START = 3'b001, RX_DATA = 3'b011,
    RX_PAR  = 3'b010, RX_STOP  = 3'b110
  } rx_state_type;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
  } apb_req_type;

  typedef struct packed {
    logic [7:0]       mod_cfg;
    logic [7:0]       line_fmt;
    logic [7:0]       irq_mask;
    logic [7:0]       tx_data;
    logic [7:0]       rx_data;
    logic [7:0]       flags;
    logic             tx_full;
    logic             tx_starved;
    tx_state_type     tx_state;
    logic [CNT_W-1:0] tx_cnt;
    logic [7:0]       tx_sh;
    logic [3:0]       tx_idx;
    logic             tx_par;
    logic             tx_bit;
    rx_state_type     rx_state;
    logic [CNT_W-1:0] rx_cnt;
    logic [7:0]       rx_sh;
    logic [3:0]       rx_idx;
    logic             rx_par;
    logic             rx_bad;
    logic             rx_unread;
    logic             ring_prev;
    logic             irq_n;
    logic             pready;
    logic             pslverr;
    logic [31:0]      prdata;
  } state_type;

endpackage

// [src/sync_agree.sv]
// three-stage input synchroniser that accepts a change once stages two and three agree
`timescale 1ns/1ns
module sync_agree #(
  parameter int         WIDTH   = 2,
  parameter logic [1:0] RST_VAL = 2'b00
) (
  input  wire logic             pclk,     // system clock
  input  wire logic             presetn,  // async reset, active low
  input  wire logic [WIDTH-1:0] din,      // raw pin levels
  output logic      [WIDTH-1:0] dout      // filtered levels
);

  // ==========================================================
  // per-bit chain; stage one feeds only stage two
  for (genvar i = 0; i < WIDTH; i++) begin : g_bit
    logic s1_ff;
    logic s2_ff;
    logic s3_ff;
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        s1_ff   <= RST_VAL[i];
        s2_ff   <= RST_VAL[i];
        s3_ff   <= RST_VAL[i];
        dout[i] <= RST_VAL[i];
      end else begin
        s1_ff <= din[i];
        s2_ff <= s1_ff;
        s3_ff <= s2_ff;
        // a one-cycle glitch never makes stages two and three agree
        if (s2_ff == s3_ff) begin
          dout[i] <= s3_ff;
        end
      end
    end
  end

endmodule

// [src/fsk_modem_char_uart.sv]
// character framing unit between apb registers and the fsk modulator/demodulator
// Notes on behaviour
// - mod config bit 3 picks raw/framed tx
// - raw tx sends 8 bits lsb first
// - framed tx begins with space start bit
// - then 7 or 8 data bits, lsb first
// - optional even/odd parity from format bits 1,2
// - one or two mark stop bits
// - transmit only while mod config bit 1 set
// - missing byte sets tx underflow flag
// - framed underflow sends mark until reload
// - raw underflow resends held byte
// - mod config bit 7 picks raw/framed rx
// - raw rx packs 8 bits, first at d0
// - framed rx: start, data, parity, stop
// - bad parity sets flag bit 7
// - each rx load sets rx ready flag
// - load before read also sets overflow
// - ring level mirrored; any change sets flag
// - ring logic runs in every mode
// - format bit 6 enables inverted driver
// - irq low on masked flags 0-3,5
// - flag read clears bits 0-3,5 and irq
`timescale 1ns/1ns
module fsk_modem_char_uart #(
  parameter int CYC_HI  = fsk_uart_pkg::CYC_HI,
  parameter int CYC_MID = fsk_uart_pkg::CYC_MID,
  parameter int CYC_LO  = fsk_uart_pkg::CYC_LO
) (
  input  wire logic                       pclk,      // system clock
  input  wire logic                       presetn,   // async reset, active low
  input  wire fsk_uart_pkg::apb_req_type  apb_req,   // apb request group
  output logic                            pready,    // apb ready
  output logic                            pslverr,   // apb error, unmapped address
  output logic [31:0]                     prdata,    // apb read data
  input  wire logic                       rx_bit,    // demodulated data pin
  input  wire logic                       ring_det,  // ring detector pin
  output logic                            tx_bit,    // data to the modulator
  output logic                            tx_inv_en, // inverted line driver enable
  output logic                            irq_n      // interrupt, active low
);

  fsk_uart_pkg::state_type s_ff;
  fsk_uart_pkg::state_type nxt_s;
  logic [1:0]              pins_s;
  logic                    rx_s;
  logic                    ring_s;

  // ==========================================================
  // pin synchronisers; idle line is mark
  sync_agree #(.WIDTH(2), .RST_VAL(2'b01)) u_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .din     ({ring_det, rx_bit}),
    .dout    (pins_s)
  );
  assign rx_s   = pins_s[0];
  assign ring_s = pins_s[1];

  // ==========================================================
  // outputs all come straight from state flops
  assign pready    = s_ff.pready;
  assign pslverr   = s_ff.pslverr;
  assign prdata    = s_ff.prdata;
  assign tx_bit    = s_ff.tx_bit;
  assign irq_n     = s_ff.irq_n;
  assign tx_inv_en = s_ff.line_fmt[fsk_uart_pkg::FMT_TXINV];

  // ==========================================================
  // next-state logic
  always_comb begin
    logic [fsk_uart_pkg::CNT_W-1:0] per;
    logic [3:0]                     ndata;
    logic                           fetch;
    logic                           ld;
    logic [7:0]                     ld_val;
    logic                           ld_bad;
    logic                           done;
    logic                           mapped;
    logic [7:0]                     rd;
    per    = '0;
    ndata  = '0;
    fetch  = 1'b0;
    ld     = 1'b0;
    ld_val = '0;
    ld_bad = 1'b0;
    done   = 1'b0;
    mapped = 1'b0;
    rd     = '0;
    nxt_s  = s_ff;

    // bit period from the selected line rate
    if (s_ff.mod_cfg[fsk_uart_pkg::MOD_HI_RATE]) begin
      per = fsk_uart_pkg::CNT_W'(CYC_HI);
    end else if (s_ff.line_fmt[fsk_uart_pkg::FMT_SLOW150]) begin
      per = fsk_uart_pkg::CNT_W'(CYC_MID);
    end else begin
      per = fsk_uart_pkg::CNT_W'(CYC_LO);
    end
    ndata = s_ff.line_fmt[fsk_uart_pkg::FMT_DATA8] ? fsk_uart_pkg::DATA_N8
                                                   : fsk_uart_pkg::DATA_N7;

    // apb read side effects of the completing access come first so that
    // hardware sets below win over a clear in the same cycle
    done = apb_req.psel && apb_req.penable && s_ff.pready;
    if (done && !s_ff.pslverr && !apb_req.pwrite) begin
      if (apb_req.paddr == fsk_uart_pkg::OFS_FLAGS) begin
        // clear only what the read actually reported
        nxt_s.flags = s_ff.flags & ~(s_ff.prdata[7:0] & fsk_uart_pkg::FLG_EVENTS);
      end
      if (apb_req.paddr == fsk_uart_pkg::OFS_RX_DATA) begin
        nxt_s.rx_unread = 1'b0;
      end
    end

    // transmitter
    if (!s_ff.mod_cfg[fsk_uart_pkg::MOD_TX_EN]) begin
      // idle at mark while transmit is off
      nxt_s.tx_state   = fsk_uart_pkg::TX_IDLE;
      nxt_s.tx_bit     = 1'b1;
      nxt_s.tx_cnt     = '0;
      nxt_s.tx_starved = 1'b0;
    end else if (s_ff.tx_cnt != '0) begin
      nxt_s.tx_cnt = s_ff.tx_cnt - 1'b1;
    end else begin
      nxt_s.tx_cnt = per - 1'b1;
      case (s_ff.tx_state)
        fsk_uart_pkg::TX_IDLE: begin
          fetch = 1'b1;
        end
        fsk_uart_pkg::TX_START: begin
          // first data bit follows the start bit
          nxt_s.tx_bit   = s_ff.tx_sh[0];
          nxt_s.tx_par   = s_ff.tx_par ^ s_ff.tx_sh[0];
          nxt_s.tx_sh    = {1'b0, s_ff.tx_sh[7:1]};
          nxt_s.tx_idx   = 4'h1;
          nxt_s.tx_state = fsk_uart_pkg::TX_DATA;
        end
        fsk_uart_pkg::TX_DATA: begin
          if (!s_ff.mod_cfg[fsk_uart_pkg::MOD_TX_ASYNC]) begin
            // raw byte, lsb first, back to back
            if (s_ff.tx_idx == fsk_uart_pkg::DATA_N8) begin
              fetch = 1'b1;
            end else begin
              nxt_s.tx_bit = s_ff.tx_sh[0];
              nxt_s.tx_sh  = {1'b0, s_ff.tx_sh[7:1]};
              nxt_s.tx_idx = s_ff.tx_idx + 1'b1;
            end
          end else if (s_ff.tx_idx == ndata) begin
            // parity bit: even carries the data xor
            if (s_ff.line_fmt[fsk_uart_pkg::FMT_PAR_EN]) begin
              nxt_s.tx_bit   = s_ff.line_fmt[fsk_uart_pkg::FMT_PAR_EVEN] ? s_ff.tx_par
                                                                         : ~s_ff.tx_par;
              nxt_s.tx_state = fsk_uart_pkg::TX_PAR;
            end else begin
              nxt_s.tx_bit   = 1'b1;
              nxt_s.tx_idx   = '0;
              nxt_s.tx_state = fsk_uart_pkg::TX_STOP;
            end
          end else begin
            nxt_s.tx_bit = s_ff.tx_sh[0];
            nxt_s.tx_par = s_ff.tx_par ^ s_ff.tx_sh[0];
            nxt_s.tx_sh  = {1'b0, s_ff.tx_sh[7:1]};
            nxt_s.tx_idx = s_ff.tx_idx + 1'b1;
          end
        end
        fsk_uart_pkg::TX_PAR: begin
          nxt_s.tx_bit   = 1'b1;
          nxt_s.tx_idx   = '0;
          nxt_s.tx_state = fsk_uart_pkg::TX_STOP;
        end
        fsk_uart_pkg::TX_STOP: begin
          // second mark period when two stops selected
          if (s_ff.line_fmt[fsk_uart_pkg::FMT_STOP2] && s_ff.tx_idx == '0) begin
            nxt_s.tx_idx = 4'h1;
            nxt_s.tx_bit = 1'b1;
          end else begin
            fetch = 1'b1;
          end
        end
        default: begin
          nxt_s.tx_state = fsk_uart_pkg::TX_IDLE;
          nxt_s.tx_bit   = 1'b1;
        end
      endcase
    end

    // byte fetch at a character boundary
    if (fetch) begin
      // framing chosen per byte at fetch time
      nxt_s.tx_par = 1'b0;
      if (s_ff.tx_full) begin
        // byte taken, host may load the next
        nxt_s.tx_full                       = 1'b0;
        nxt_s.tx_starved                    = 1'b0;
        nxt_s.flags[fsk_uart_pkg::FLG_TX_RDY] = 1'b1;
      end else begin
        if (!s_ff.tx_starved) begin
          nxt_s.flags[fsk_uart_pkg::FLG_TX_UND] = 1'b1;
        end
        nxt_s.tx_starved = 1'b1;
      end
      if (s_ff.mod_cfg[fsk_uart_pkg::MOD_TX_ASYNC]) begin
        if (s_ff.tx_full) begin
          nxt_s.tx_bit   = 1'b0;
          nxt_s.tx_sh    = s_ff.tx_data;
          nxt_s.tx_state = fsk_uart_pkg::TX_START;
        end else begin
          // mark for a bit time, then try again
          nxt_s.tx_bit   = 1'b1;
          nxt_s.tx_state = fsk_uart_pkg::TX_IDLE;
        end
      end else begin
        // raw mode resends the held byte when starved
        nxt_s.tx_bit   = s_ff.tx_data[0];
        nxt_s.tx_sh    = {1'b0, s_ff.tx_data[7:1]};
        nxt_s.tx_idx   = 4'h1;
        nxt_s.tx_state = fsk_uart_pkg::TX_DATA;
      end
    end

    // receiver
    if (!s_ff.mod_cfg[fsk_uart_pkg::MOD_RX_ASYNC]) begin
      // raw receive has no framing state
      nxt_s.rx_state = fsk_uart_pkg::RX_IDLE;
      if (s_ff.rx_cnt != '0) begin
        nxt_s.rx_cnt = s_ff.rx_cnt - 1'b1;
      end else begin
        // shift in at the top so the first bit ends at d0
        nxt_s.rx_cnt = per - 1'b1;
        nxt_s.rx_sh  = {rx_s, s_ff.rx_sh[7:1]};
        if (s_ff.rx_idx == fsk_uart_pkg::DATA_N7) begin
          nxt_s.rx_idx = '0;
          ld           = 1'b1;
          ld_val       = {rx_s, s_ff.rx_sh[7:1]};
        end else begin
          nxt_s.rx_idx = s_ff.rx_idx + 1'b1;
        end
      end
    end else if (s_ff.rx_state == fsk_uart_pkg::RX_IDLE) begin
      // half a bit to the start bit centre
      if (!rx_s) begin
        nxt_s.rx_cnt   = {1'b0, per[fsk_uart_pkg::CNT_W-1:1]};
        nxt_s.rx_state = fsk_uart_pkg::RX_START;
      end
    end else if (s_ff.rx_cnt != '0) begin
      nxt_s.rx_cnt = s_ff.rx_cnt - 1'b1;
    end else begin
      nxt_s.rx_cnt = per - 1'b1;
      case (s_ff.rx_state)
        fsk_uart_pkg::RX_START: begin
          // a start bit gone high at its centre was noise
          nxt_s.rx_idx   = '0;
          nxt_s.rx_par   = 1'b0;
          nxt_s.rx_bad   = 1'b0;
          nxt_s.rx_state = rx_s ? fsk_uart_pkg::RX_IDLE : fsk_uart_pkg::RX_DATA;
        end
        fsk_uart_pkg::RX_DATA: begin
          nxt_s.rx_sh  = {rx_s, s_ff.rx_sh[7:1]};
          nxt_s.rx_par = s_ff.rx_par ^ rx_s;
          nxt_s.rx_idx = s_ff.rx_idx + 1'b1;
          if (s_ff.rx_idx == ndata - 1'b1) begin
            nxt_s.rx_state = s_ff.line_fmt[fsk_uart_pkg::FMT_PAR_EN] ? fsk_uart_pkg::RX_PAR
                                                                     : fsk_uart_pkg::RX_STOP;
          end
        end
        fsk_uart_pkg::RX_PAR: begin
          nxt_s.rx_bad   = (s_ff.rx_par ^ rx_s) ^ ~s_ff.line_fmt[fsk_uart_pkg::FMT_PAR_EVEN];
          nxt_s.rx_state = fsk_uart_pkg::RX_STOP;
        end
        fsk_uart_pkg::RX_STOP: begin
          // a space stop bit drops the character
          nxt_s.rx_state = fsk_uart_pkg::RX_IDLE;
          if (rx_s) begin
            ld     = 1'b1;
            ld_bad = s_ff.line_fmt[fsk_uart_pkg::FMT_PAR_EN] & s_ff.rx_bad;
            ld_val = s_ff.line_fmt[fsk_uart_pkg::FMT_DATA8] ? s_ff.rx_sh
                                                            : {1'b0, s_ff.rx_sh[7:1]};
          end
        end
        default: begin
          nxt_s.rx_state = fsk_uart_pkg::RX_IDLE;
        end
      endcase
    end

    if (ld) begin
      nxt_s.rx_data                          = ld_val;
      nxt_s.rx_unread                        = 1'b1;
      nxt_s.flags[fsk_uart_pkg::FLG_RX_RDY]  = 1'b1;
      nxt_s.flags[fsk_uart_pkg::FLG_BAD_PAR] = ld_bad;
      if (s_ff.rx_unread) begin
        nxt_s.flags[fsk_uart_pkg::FLG_RX_OVF] = 1'b1;
      end
    end

    // ring tracking has no mode or enable gating
    nxt_s.ring_prev                     = ring_s;
    nxt_s.flags[fsk_uart_pkg::FLG_RING] = ring_s;
    if (ring_s != s_ff.ring_prev) begin
      nxt_s.flags[fsk_uart_pkg::FLG_RING_CHG] = 1'b1;
    end
    nxt_s.flags[4] = 1'b0;

    nxt_s.irq_n = ~|(s_ff.flags & s_ff.irq_mask & fsk_uart_pkg::FLG_EVENTS);

    // apb: one wait state, answer and read data registered together
    case (apb_req.paddr)
      fsk_uart_pkg::OFS_MOD_CFG:  rd = s_ff.mod_cfg;
      fsk_uart_pkg::OFS_LINE_FMT: rd = s_ff.line_fmt;
      fsk_uart_pkg::OFS_IRQ_MASK: rd = s_ff.irq_mask;
      fsk_uart_pkg::OFS_TX_DATA:  rd = s_ff.tx_data;
      fsk_uart_pkg::OFS_RX_DATA:  rd = s_ff.rx_data;
      fsk_uart_pkg::OFS_FLAGS:    rd = s_ff.flags;
      default:                    rd = '0;
    endcase
    mapped = (apb_req.paddr <= fsk_uart_pkg::OFS_FLAGS) && (apb_req.paddr[1:0] == 2'b00);
    nxt_s.pready  = apb_req.psel && apb_req.penable && !s_ff.pready;
    nxt_s.pslverr = apb_req.psel && apb_req.penable && !s_ff.pready && !mapped;
    if (apb_req.psel && apb_req.penable && !s_ff.pready) begin
      nxt_s.prdata = apb_req.pwrite ? 32'h0000_0000 : {24'h00_0000, rd};
    end

    // writes last so a load in a fetch cycle is kept
    if (done && !s_ff.pslverr && apb_req.pwrite) begin
      case (apb_req.paddr)
        fsk_uart_pkg::OFS_MOD_CFG:  nxt_s.mod_cfg  = apb_req.pwdata[7:0];
        fsk_uart_pkg::OFS_LINE_FMT: nxt_s.line_fmt = apb_req.pwdata[7:0];
        fsk_uart_pkg::OFS_IRQ_MASK: nxt_s.irq_mask = apb_req.pwdata[7:0];
        fsk_uart_pkg::OFS_TX_DATA: begin
          nxt_s.tx_data = apb_req.pwdata[7:0];
          nxt_s.tx_full = 1'b1;
        end
        default: begin
        end
      endcase
    end
  end

  // ==========================================================
  // state register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_ff           <= '0;
      s_ff.tx_bit    <= 1'b1;
      s_ff.ring_prev <= 1'b0;
      s_ff.irq_n     <= 1'b1;
      s_ff.mod_cfg   <= fsk_uart_pkg::RST_REG;
      s_ff.line_fmt  <= fsk_uart_pkg::RST_REG;
      s_ff.irq_mask  <= fsk_uart_pkg::RST_REG;
    end else begin
      s_ff <= nxt_s;
    end
  end

endmodule

// [verification/fsk_uart_props.sv]
// checker for the fsk character uart: bus handshake, driver enable, idle line, interrupt
`timescale 1ns/1ns
module fsk_uart_props (
  input wire logic                      pclk,      // clock
  input wire logic                      presetn,   // reset, active low
  input wire fsk_uart_pkg::apb_req_type apb_req,   // bus request
  input wire logic                      pready,    // bus ready
  input wire logic                      pslverr,   // bus error
  input wire logic [31:0]               prdata,    // read data
  input wire logic                      rx_bit,    // demodulated pin
  input wire logic                      ring_det,  // ring pin
  input wire logic                      tx_bit,    // modulator data
  input wire logic                      tx_inv_en, // inverted driver enable
  input wire logic                      irq_n      // interrupt, active low
);
  // ==========================================================
  // completed-access decodes; paddr is held by the master while pready is high
  logic wr_fmt, wr_mod, wr_mask, rd_flags, bad_addr;
  assign wr_fmt   = pready && apb_req.pwrite && apb_req.paddr == fsk_uart_pkg::OFS_LINE_FMT;
  assign wr_mod   = pready && apb_req.pwrite && apb_req.paddr == fsk_uart_pkg::OFS_MOD_CFG;
  assign wr_mask  = pready && apb_req.pwrite && apb_req.paddr == fsk_uart_pkg::OFS_IRQ_MASK;
  assign rd_flags = pready && !apb_req.pwrite && apb_req.paddr == fsk_uart_pkg::OFS_FLAGS;
  assign bad_addr = apb_req.paddr > fsk_uart_pkg::OFS_FLAGS || apb_req.paddr[1:0] != 2'h0;

  // ==========================================================
  // properties
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_ready_next: assert property (apb_req.psel && apb_req.penable && !pready |=> pready)
    else $error("ready not one cycle after access");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  a_err_decode: assert property (pready |-> pslverr == bad_addr)
    else $error("error flag does not match address decode");
  a_inv_on: assert property (wr_fmt && apb_req.pwdata[6] |-> ##[1:3] tx_inv_en)
    else $error("inverted driver not enabled");
  a_inv_off: assert property (wr_fmt && !apb_req.pwdata[6] |-> ##[1:3] !tx_inv_en)
    else $error("inverted driver not disabled");
  a_tx_idle: assert property (wr_mod && !apb_req.pwdata[1] |-> ##[1:3] tx_bit)
    else $error("line not at mark with transmit off");
  a_irq_unmask: assert property (wr_mask && ~|apb_req.pwdata[7:0] |-> ##[1:3] irq_n)
    else $error("interrupt held with all masks clear");
  a_irq_clear: assert property (rd_flags && !irq_n |-> ##[1:3] irq_n)
    else $error("interrupt not released by flag read");
  a_rdata_upper: assert property (rd_flags |-> prdata[31:8] == 24'h0 && !prdata[4])
    else $error("flag read carries stray bits");
endmodule

bind fsk_modem_char_uart fsk_uart_props i_props (
  .pclk(pclk), .presetn(presetn), .apb_req(apb_req), .pready(pready), .pslverr(pslverr),
  .prdata(prdata), .rx_bit(rx_bit), .ring_det(ring_det), .tx_bit(tx_bit),
  .tx_inv_en(tx_inv_en), .irq_n(irq_n)
);

// [verification/fsk_line_model.sv]
// demodulator-side model: idle mark, framed characters and steady levels
`timescale 1ns/1ns
module fsk_line_model #(
  parameter int CYC = 20  // clock cycles per bit
) (
  input  wire logic pclk,   // clock
  output logic      rx_bit  // demodulated data to the block
);
  // idle line is mark, as a quiet demodulator gives
  initial rx_bit = 1'b1;

  // one bit period, changed just after an edge
  task automatic put(input logic v);
    @(posedge pclk);
    rx_bit <= v;
    repeat (CYC - 1) @(posedge pclk);
  endtask

  // steady level for raw patterns
  task automatic hold(input logic v);
    @(posedge pclk);
    rx_bit <= v;
  endtask

  // start, data lsb first, optional parity, one stop; parity given raw so errors can be sent
  task automatic send(input logic [7:0] d, input int nd, input logic np, input logic p);
    put(1'b0);
    for (int i = 0; i < nd; i++) put(d[i]);
    if (np) put(p);
    put(1'b1);
  endtask
endmodule

// [verification/fsk_modem_char_uart_tb.sv]
// self-checking bench for the fsk character uart
`timescale 1ns/1ns
module fsk_modem_char_uart_tb;
  localparam int CYC = 20;
  logic                      pclk, presetn, ring_det, rx_bit, perr;
  logic                      pready, pslverr, tx_bit, tx_inv_en, irq_n;
  logic [31:0]               prdata, q;
  fsk_uart_pkg::apb_req_type req;
  int                        err_total, n_checks;

  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end

  fsk_modem_char_uart #(.CYC_HI(CYC), .CYC_MID(40), .CYC_LO(60)) i_dut (
    .pclk(pclk), .presetn(presetn), .apb_req(req), .pready(pready), .pslverr(pslverr),
    .prdata(prdata), .rx_bit(rx_bit), .ring_det(ring_det), .tx_bit(tx_bit),
    .tx_inv_en(tx_inv_en), .irq_n(irq_n));
  fsk_line_model #(.CYC(CYC)) i_line (.pclk(pclk), .rx_bit(rx_bit));

  // ==========================================================
  // report, compare and bus tasks
  task automatic tally_and_finish();
    if (err_total == 0 && n_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask

  // one transfer; the wait is bounded so a dead slave ends the run
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
    @(posedge pclk);
    req.penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    q = prdata;
    perr = pslverr;
    req.psel <= 1'b0;
    req.penable <= 1'b0;
    if (n >= 20) begin
      err_total++;
      tally_and_finish();
    end
  endtask

  // ==========================================================
  // scenarios
  task automatic t_regs();
    chk("tx_bit", 1, tx_bit);
    chk("irq_n", 1, irq_n);
    apb(0, fsk_uart_pkg::OFS_MOD_CFG, 0);
    chk("mod_cfg", 0, q);
    apb(1, fsk_uart_pkg::OFS_IRQ_MASK, 32'h5a);
    apb(0, fsk_uart_pkg::OFS_IRQ_MASK, 0);
    chk("irq_mask", 32'h5a, q);
    apb(1, fsk_uart_pkg::OFS_IRQ_MASK, 0);
    apb(0, 8'h18, 0);
    chk("pslverr", 1, perr);
    apb(1, fsk_uart_pkg::OFS_LINE_FMT, 32'h40);
    repeat (3) @(posedge pclk);
    chk("tx_inv_en", 1, tx_inv_en);
    apb(1, fsk_uart_pkg::OFS_LINE_FMT, 0);
    repeat (3) @(posedge pclk);
    chk("tx_inv_en", 0, tx_inv_en);
  endtask

  // one byte then starvation; samples near each bit centre
  task automatic t_tx(input logic [7:0] m, input logic [7:0] f, input logic [7:0] d, input int c);
    logic       ex[$];
    logic [7:0] dm;
    dm = f[0] ? d : {1'b0, d[6:0]};
    apb(1, fsk_uart_pkg::OFS_MOD_CFG, 0);
    apb(1, fsk_uart_pkg::OFS_LINE_FMT, {24'h0, f});
    apb(1, fsk_uart_pkg::OFS_TX_DATA, {24'h0, d});
    apb(0, fsk_uart_pkg::OFS_FLAGS, 0);
    if (m[3]) begin
      ex.push_back(1'b0);
      for (int i = 0; i < (f[0] ? 8 : 7); i++) ex.push_back(d[i]);
      if (f[2]) ex.push_back(f[1] ? ^dm : ~^dm);
      repeat (f[3] ? 4 : 3) ex.push_back(1'b1);
    end else begin
      for (int i = 0; i < 16; i++) ex.push_back(d[i % 8]);
    end
    apb(1, fsk_uart_pkg::OFS_MOD_CFG, {24'h0, m});
    // c is the bit period of the selected rate; first sample lands mid first bit, the start bit when framed
    repeat (c / 2) @(posedge pclk);
    foreach (ex[i]) begin
      chk("tx_bit", ex[i], tx_bit);
      repeat (c) @(posedge pclk);
    end
    apb(0, fsk_uart_pkg::OFS_FLAGS, 0);
    chk("tx flags", 32'h3, q & 32'h3);
  endtask

  task automatic t_rx_framed();
    apb(1, fsk_uart_pkg::OFS_MOD_CFG, 32'h81);
    apb(1, fsk_uart_pkg::OFS_LINE_FMT, 32'h07);
    apb(0, fsk_uart_pkg::OFS_RX_DATA, 0);
    apb(0, fsk_uart_pkg::OFS_FLAGS, 0);
    i_line.send(8'h5a, 8, 1'b1, 1'b1);
    repeat (CYC) @(posedge pclk);
    apb(0, fsk_uart_pkg::OFS_RX_DATA, 0);
    chk("rx_data", 32'h5a, q);
    apb(0, fsk_uart_pkg::OFS_FLAGS, 0);
    chk("rx flags", 32'h84, q & 32'h8c);
    i_line.send(8'h3c, 8, 1'b1, 1'b0);
    i_line.send(8'h0f, 8, 1'b1, 1'b0);
    repeat (CYC) @(posedge pclk);
    apb(0, fsk_uart_pkg::OFS_FLAGS, 0);
    chk("rx flags", 32'h0c, q & 32'h8c);
    apb(0, fsk_uart_pkg::OFS_RX_DATA, 0);
    chk("rx_data", 32'h0f, q);
  endtask

  // raw receive has no alignment, so only steady levels give a known byte
  task automatic t_rx_raw();
    apb(1, fsk_uart_pkg::OFS_MOD_CFG, 32'h01);
    for (int v = 0; v < 2; v++) begin
      i_line.hold(v[0]);
      repeat (17 * CYC) @(posedge pclk);
      apb(0, fsk_uart_pkg::OFS_RX_DATA, 0);
      chk("rx_data", v[0] ? 32'hff : 32'h00, q);
    end
  endtask

  task automatic t_ring();
    apb(1, fsk_uart_pkg::OFS_IRQ_MASK, 32'h20);
    apb(0, fsk_uart_pkg::OFS_FLAGS, 0);
    ring_det <= 1'b1;
    repeat (10) @(posedge pclk);
    chk("irq_n", 0, irq_n);
    apb(0, fsk_uart_pkg::OFS_FLAGS, 0);
    chk("ring flags", 32'h60, q & 32'h60);
    repeat (3) @(posedge pclk);
    chk("irq_n", 1, irq_n);
    apb(0, fsk_uart_pkg::OFS_FLAGS, 0);
    chk("ring flags", 32'h40, q & 32'h60);
    ring_det <= 1'b0;
    repeat (10) @(posedge pclk);
    apb(0, fsk_uart_pkg::OFS_FLAGS, 0);
    chk("ring flags", 32'h20, q & 32'h60);
    // mask bit left clear when the detector is not wanted
    apb(1, fsk_uart_pkg::OFS_IRQ_MASK, 0);
    ring_det <= 1'b1;
    repeat (10) @(posedge pclk);
    chk("irq_n", 1, irq_n);
  endtask

  // ==========================================================
  // main sequence
  initial begin
    req = '0;
    presetn = 1'b0;
    ring_det = 1'b0;
    err_total = 0;
    n_checks = 0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_tx(8'h0b, 8'h0f, 8'ha5, CYC);
    t_tx(8'h0b, 8'h04, 8'h83, CYC);
    t_tx(8'h03, 8'h00, 8'h3c, CYC);
    // the two slower rates: framed at the middle rate, raw at the lowest
    t_tx(8'h0a, 8'h81, 8'h96, 40);
    t_tx(8'h02, 8'h00, 8'h6b, 60);
    t_rx_framed();
    t_rx_raw();
    t_ring();
    tally_and_finish();
  end
endmodule
